// file: common/pcs_pkg.sv
// Purpose: constants and carriers for the 16-bit card control strobe block
// Assumes: one 100 MHz clock, strobes active low at the card pins
// Notes:   strobe and setup widths are counted in core clock cycles
package pcs_pkg;

   localparam int unsigned CLK_PERIOD_NS = 10;
   // address and select setup before a strobe, and strobe width
   localparam int unsigned SETUP_NS      = 30;
   localparam int unsigned STROBE_NS     = 100;
   localparam int unsigned HOLD_NS       = 20;
   localparam int unsigned SETUP_CYC  =
      (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_CYC =
      (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_CYC   =
      (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 4;

   typedef enum logic [2:0] {
      PCS_OP_MEM_RD,
      PCS_OP_MEM_WR,
      PCS_OP_IO_RD,
      PCS_OP_IO_WR,
      PCS_OP_DMA_RD,   // host memory to card
      PCS_OP_DMA_WR    // card to host memory
   } pcs_op_e;

   typedef struct packed {
      pcs_op_e    op;
      logic       attr;    // attribute space for memory cycles
      logic       a0;      // byte address bit 0
      logic       wide;    // 16-bit access, both bytes
      logic       tc;      // last dma item
   } pcs_req_s;

   // card-side strobes, all active low
   typedef struct packed {
      logic ce1_n;
      logic ce2_n;
      logic reg_n;
      logic oe_n;
      logic we_n;
      logic iord_n;
      logic iowr_n;
   } pcs_strb_s;

   localparam pcs_strb_s PCS_IDLE = '{default: 1'b1};

endpackage

// file: logic/pcs_ctrl.sv
// Purpose: drives card enables, select and read/write strobes per cycle
// Assumes: card status inputs synchronous to core_clk_i
// Notes:   wait from the card stretches the strobe phase
module pcs_ctrl
(
   input  wire logic             core_clk_i,  // 100 MHz clock
   input  wire logic             rstn_i,      // async reset, active low
   input  wire pcs_pkg::pcs_req_s req_i,      // cycle description
   input  wire logic             req_valid_i, // request present
   output logic                  req_ready_o, // request taken
   output logic                  done_o,      // one-cycle pulse at end
   input  wire logic             io_mode_i,   // socket in io interface
   input  wire logic             wait_n_i,    // card wait, low extends
   input  wire logic             inpack_n_i,  // card input ack / dma req
   input  wire logic             ready_i,     // card ready / irq_n
   output logic                  dma_req_o,   // card asks for dma
   output logic                  card_busy_o, // memory card busy
   output logic                  card_irq_o,  // io card interrupt
   output logic                  io_ack_o,    // card acked io read
   output pcs_pkg::pcs_strb_s    strb_o       // card strobes
);
   import pcs_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} st_e;

   st_e                st_r;
   pcs_req_s           req_r;
   logic [CNT_W-1:0]   cnt_r;
   pcs_strb_s          strb_r;
   pcs_strb_s          addr_nxt;
   pcs_strb_s          full_nxt;
   logic               ack_r;
   logic               take;
   logic               cnt_zero;

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      cyc = CNT_W'(n - 1);
   endfunction

   // active-low enable for one byte lane; odd picks the second enable
   function automatic logic lane_off(input pcs_req_s r, input logic odd);
      lane_off = ~(r.wide | (r.a0 == odd));
   endfunction

   // select lines only: enables and attribute select, strobes idle
   always_comb
   begin
      addr_nxt = PCS_IDLE;
      addr_nxt.ce1_n = lane_off(req_r, 1'b0);
      addr_nxt.ce2_n = lane_off(req_r, 1'b1);
      case (req_r.op)
         PCS_OP_MEM_RD,
         PCS_OP_MEM_WR: addr_nxt.reg_n = ~req_r.attr;
         PCS_OP_IO_RD,
         PCS_OP_IO_WR:  addr_nxt.reg_n = 1'b0;
         default:       addr_nxt.reg_n = 1'b0;
      endcase
   end

   // one read or write strobe per operation; dma also drives we_n or oe_n low on the tc item
   always_comb
   begin
      full_nxt = addr_nxt;
      case (req_r.op)
         PCS_OP_MEM_RD: full_nxt.oe_n   = 1'b0;
         PCS_OP_MEM_WR: full_nxt.we_n   = 1'b0;
         PCS_OP_IO_RD:  full_nxt.iord_n = 1'b0;
         PCS_OP_IO_WR:  full_nxt.iowr_n = 1'b0;
         PCS_OP_DMA_RD:
         begin
            full_nxt.iowr_n = 1'b0;
            full_nxt.we_n   = ~req_r.tc;
         end
         PCS_OP_DMA_WR:
         begin
            full_nxt.iord_n = 1'b0;
            full_nxt.oe_n   = ~req_r.tc;
         end
         default: full_nxt = addr_nxt;
      endcase
   end

   assign req_ready_o = (st_r == ST_IDLE);
   assign take        = (st_r == ST_IDLE) && req_valid_i;
   // each phase ends when its down counter reaches zero; the strobe phase also waits for wait_n_i high
   assign cnt_zero    = (cnt_r == '0);

   // request held for the whole cycle so the decodes stay stable
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         req_r <= '0;
      else if (take)
         req_r <= req_i;
   end

   // phase sequence: select setup, strobe, select hold
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_r <= ST_IDLE;
      else
      begin
         case (st_r)
            ST_IDLE:
               if (take)
                  st_r <= ST_SETUP;
            ST_SETUP:
               if (cnt_zero)
                  st_r <= ST_STROBE;
            ST_STROBE:
               // card wait only counts once the minimum width has run
               if (cnt_zero && wait_n_i)
                  st_r <= ST_HOLD;
            ST_HOLD:
               if (cnt_zero)
                  st_r <= ST_IDLE;
            default:
               st_r <= ST_IDLE;
         endcase
      end
   end

   // phase length, reloaded as each phase begins
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_r <= '0;
      else
      begin
         case (st_r)
            ST_IDLE:
               if (take)
                  cnt_r <= cyc(SETUP_CYC);
            ST_SETUP:
               if (cnt_zero)
                  cnt_r <= cyc(STROBE_CYC);
               else
                  cnt_r <= cnt_r - 1'b1;
            ST_STROBE:
               if (!cnt_zero)
                  cnt_r <= cnt_r - 1'b1;
               else if (wait_n_i)
                  cnt_r <= cyc(HOLD_CYC);
            ST_HOLD:
               if (!cnt_zero)
                  cnt_r <= cnt_r - 1'b1;
            default:
               cnt_r <= '0;
         endcase
      end
   end

   // strobes registered; select driven from the second setup cycle and held through hold
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         strb_r <= PCS_IDLE;
      else
      begin
         case (st_r)
            ST_SETUP:
               if (cnt_zero)
                  strb_r <= full_nxt;
               else
                  strb_r <= addr_nxt;
            ST_STROBE:
               if (cnt_zero && wait_n_i)
                  strb_r <= addr_nxt;
            ST_HOLD:
               if (cnt_zero)
                  strb_r <= PCS_IDLE;
            // idle, and any unreachable code, parks every line high
            default:
               strb_r <= PCS_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         done_o <= 1'b0;
      else
         done_o <= (st_r == ST_HOLD) && (cnt_r == '0);
   end

   // input acknowledge latched while an io read strobe is active
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ack_r <= 1'b0;
      else if (st_r == ST_SETUP && req_r.op == PCS_OP_IO_RD)
         ack_r <= 1'b0;
      else if (!strb_r.iord_n && req_r.op == PCS_OP_IO_RD && !inpack_n_i)
         ack_r <= 1'b1;
   end

   // card status lines, meaning set by socket mode
   // the ready pin means busy in memory mode and interrupt in io mode
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dma_req_o   <= 1'b0;
         card_busy_o <= 1'b0;
         card_irq_o  <= 1'b0;
         io_ack_o    <= 1'b0;
      end
      else
      begin
         dma_req_o   <= io_mode_i & ~inpack_n_i & strb_r.iord_n;
         card_busy_o <= ~io_mode_i & ~ready_i;
         card_irq_o  <= io_mode_i & ~ready_i;
         io_ack_o    <= ack_r;
      end
   end

   assign strb_o = strb_r;

endmodule

// file: bench/pcs_card.sv
// Purpose: behavioural model of an inserted 16-bit memory or io card
// Assumes: strobes active low, sampled on core_clk_i
// Notes:   knobs from the bench select slow, busy, irq and dma request
module pcs_card
   import pcs_pkg::*;
(
   input  wire logic      core_clk_i, // clock
   input  wire pcs_strb_s strb_i,     // strobes from controller
   input  wire logic      io_mode_i,  // socket in io interface
   input  wire logic      slow_i,     // stretch with wait
   input  wire logic      busy_i,     // memory card busy
   input  wire logic      irq_i,      // io card wants service
   input  wire logic      dreq_i,     // card wants dma
   output logic           wait_n_o,   // wait, low extends
   output logic           inpack_n_o, // input ack / dma request
   output logic           ready_o     // ready / irq_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // slow card keeps wait low past the controller's minimum strobe width
   localparam logic [3:0] WAIT_END = 4'hc;
   logic [3:0] wc_r;
   logic       idle;
   assign idle = &{strb_i.oe_n, strb_i.we_n, strb_i.iord_n, strb_i.iowr_n};
   always_ff @(posedge core_clk_i)
      wc_r <= idle ? 4'h0 : wc_r + {3'h0, wc_r != WAIT_END};
   assign wait_n_o = !(slow_i && !idle && wc_r != WAIT_END);
   // ack only an io read; elsewhere the line carries the dma request
   assign inpack_n_o = (io_mode_i && !strb_i.iord_n) ? 1'b0 : !dreq_i;
   assign ready_o = io_mode_i ? !irq_i : !busy_i;
endmodule

// file: bench/pcs_props.sv
// Purpose: port checks for the card strobe block
// Assumes: one clock, strobes active low
// Notes:   bound into pcs_ctrl
module pcs_props
   import pcs_pkg::*;
(
   input wire logic      core_clk_i,
   input wire logic      rstn_i,
   input wire pcs_req_s  req_i,
   input wire logic      req_valid_i,
   input wire logic      req_ready_o,
   input wire logic      io_mode_i,
   input wire logic      inpack_n_i,
   input wire logic      ready_i,
   input wire logic      dma_req_o,
   input wire logic      card_busy_o,
   input wire pcs_strb_s strb_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic    tk, idl, sel;
   pcs_op_e op;
   assign tk = req_valid_i && req_ready_o;
   assign op = req_i.op;
   assign idl = &{strb_o.oe_n, strb_o.we_n, strb_o.iord_n, strb_o.iowr_n};
   assign sel = !(strb_o.ce1_n && strb_o.ce2_n);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   a_rd_wr_apart:
      assert property (!((!strb_o.oe_n || !strb_o.iord_n) &&
         (!strb_o.we_n || !strb_o.iowr_n))) else $error("rd wr overlap");
   a_sel_first:
      assert property ($fell(idl) |-> $past(sel)) else $error("no select");
   a_iord_cycle:
      assert property (tk && op inside {PCS_OP_IO_RD, PCS_OP_DMA_WR} |->
         ##4 !strb_o.iord_n) else $error("iord late");
   a_iowr_cycle:
      assert property (tk && op inside {PCS_OP_IO_WR, PCS_OP_DMA_RD} |->
         ##4 !strb_o.iowr_n) else $error("iowr late");
   a_oe_memrd:
      assert property (tk && op == PCS_OP_MEM_RD |-> ##4 !strb_o.oe_n)
         else $error("oe late");
   a_tc_oe:
      assert property (tk && req_i.tc && op == PCS_OP_DMA_WR |->
         ##4 !strb_o.oe_n) else $error("tc oe");
   a_tc_we:
      assert property (tk && req_i.tc && op == PCS_OP_DMA_RD |->
         ##4 !strb_o.we_n) else $error("tc we");
   a_common_reg:
      assert property (tk && op inside {PCS_OP_MEM_RD, PCS_OP_MEM_WR} &&
         !req_i.attr |=> strb_o.reg_n [*8]) else $error("reg low");
   a_io_reg:
      assert property (!(strb_o.iord_n && strb_o.iowr_n) |-> !strb_o.reg_n)
         else $error("reg high on io");
   a_byte_lane:
      assert property (tk && !req_i.wide |-> ##2
         (strb_o.ce1_n == $past(req_i.a0, 2) &&
          strb_o.ce2_n != $past(req_i.a0, 2))) else $error("lane");
   a_dma_flag:
      assert property (io_mode_i && !inpack_n_i && strb_o.iord_n |=>
         dma_req_o) else $error("dma req");
   a_busy_flag:
      assert property (!io_mode_i && !ready_i |=> card_busy_o)
         else $error("busy");
   cover property (tk && op == PCS_OP_DMA_RD && req_i.tc);
   cover property (dma_req_o);
   cover property (card_busy_o);
endmodule
bind pcs_ctrl pcs_props u_pcs_props(.core_clk_i(core_clk_i),
   .rstn_i(rstn_i), .req_i(req_i), .req_valid_i(req_valid_i),
   .req_ready_o(req_ready_o), .io_mode_i(io_mode_i),
   .inpack_n_i(inpack_n_i), .ready_i(ready_i), .dma_req_o(dma_req_o),
   .card_busy_o(card_busy_o), .strb_o(strb_o));

// file: bench/test_pc_card_16bit_control_strobes.sv
// Purpose: self-checking bench for the card strobe block
// Assumes: 100 MHz clock, inputs driven on the falling edge
// Notes:   table rows hold request and expected strobes mid-strobe
module test_pc_card_16bit_control_strobes;
   timeunit 1ns;
   timeprecision 1ps;
   import pcs_pkg::*;
   typedef struct packed {pcs_req_s rq; logic [6:0] ex;} pcs_row_s;
   logic      core_clk_i = 0, rstn_i = 0, req_valid_i = 0, io_mode_i = 1;
   logic      slow = 0, busy = 0, irq = 0, dreq = 0;
   logic      wait_n, inpack_n, ready, req_ready, done;
   logic      dma_req, c_busy, c_irq, io_ack;
   pcs_req_s  req_i = '0;
   pcs_strb_s strb;
   int        bad_count = 0, num_checks = 0, n, m;
   pcs_row_s  rows[8] = '{
      '{'{PCS_OP_MEM_RD, 1'b0, 1'b0, 1'b0, 1'b0}, 7'h37},
      '{'{PCS_OP_MEM_RD, 1'b1, 1'b0, 1'b1, 1'b0}, 7'h07},
      '{'{PCS_OP_MEM_WR, 1'b0, 1'b1, 1'b0, 1'b0}, 7'h5b},
      '{'{PCS_OP_IO_RD, 1'b0, 1'b0, 1'b1, 1'b0}, 7'h0d},
      '{'{PCS_OP_IO_WR, 1'b0, 1'b1, 1'b0, 1'b0}, 7'h4e},
      '{'{PCS_OP_DMA_RD, 1'b0, 1'b0, 1'b1, 1'b1}, 7'h0a},
      '{'{PCS_OP_DMA_WR, 1'b0, 1'b0, 1'b1, 1'b1}, 7'h05},
      '{'{PCS_OP_DMA_RD, 1'b0, 1'b0, 1'b1, 1'b0}, 7'h0e}};
   always #5 core_clk_i = ~core_clk_i;
   pcs_ctrl u_pcs_ctrl(.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready),
      .done_o(done), .io_mode_i(io_mode_i), .wait_n_i(wait_n),
      .inpack_n_i(inpack_n), .ready_i(ready), .dma_req_o(dma_req),
      .card_busy_o(c_busy), .card_irq_o(c_irq), .io_ack_o(io_ack),
      .strb_o(strb));
   pcs_card u_pcs_card(.core_clk_i(core_clk_i), .strb_i(strb),
      .io_mode_i(io_mode_i), .slow_i(slow), .busy_i(busy), .irq_i(irq),
      .dreq_i(dreq), .wait_n_o(wait_n), .inpack_n_o(inpack_n),
      .ready_o(ready));
   task chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task run(input pcs_req_s rq, input logic [6:0] ex, output int cyc);
      @(negedge core_clk_i);
      req_i = rq;
      req_valid_i = 1;
      @(negedge core_clk_i);
      req_valid_i = 0;
      repeat (4) @(negedge core_clk_i);
      chk(strb === ex, "strobes");
      chk(req_ready === 1'b0, "taken while busy");
      for (cyc = 5; cyc < 60 && done !== 1'b1; cyc++) @(negedge core_clk_i);
      chk(done === 1'b1 && strb === PCS_IDLE, "no done");
   endtask
   initial
   begin
      repeat (6) @(negedge core_clk_i);
      rstn_i = 1;
      foreach (rows[i]) run(rows[i].rq, rows[i].ex, n);
      chk(io_ack, "io ack");
      slow = 1;
      run(rows[3].rq, rows[3].ex, m);
      chk(m > n, "wait ignored");
      slow = 0;
      dreq = 1;
      repeat (2) @(negedge core_clk_i);
      chk(dma_req, "dma request");
      dreq = 0;
      irq = 1;
      repeat (2) @(negedge core_clk_i);
      chk(c_irq && !c_busy, "irq");
      io_mode_i = 0;
      busy = 1;
      repeat (2) @(negedge core_clk_i);
      chk(c_busy && !c_irq, "busy");
      req_i = rows[0].rq;
      req_valid_i = 1;
      repeat (6) @(negedge core_clk_i);
      req_valid_i = 0;
      rstn_i = 0;
      @(negedge core_clk_i);
      chk(strb === PCS_IDLE && req_ready && !c_busy, "reset");
      rstn_i = 1;
      run(rows[0].rq, rows[0].ex, n);
      give_verdict;
   end
   initial
   begin
      #20000;
      bad_count++;
      give_verdict;
   end
endmodule
